// ### pkg/irl_pkg.sv
// Purpose: Shared constants of the interrupt request latch block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low lane
// Notes:   Byte address of a register is four times its index
package irl_pkg;
  // ***********************************************************
  // Widths
  // ***********************************************************
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VEC_W = 4;
  localparam int unsigned EVT_W = 3;
  // ***********************************************************
  // Register indices
  // ***********************************************************
  localparam logic [13:0] IDX_REQ_FIRST = 14'h0FC0;
  localparam logic [13:0] IDX_CTRL = 14'h0FC1;
  localparam logic [13:0] IDX_PSEL = 14'h0FC2;
  localparam logic [13:0] IDX_REQ_SECOND = 14'h0FC3;
  localparam logic [13:0] IDX_STATUS = 14'h0FC4;
  localparam logic [13:0] IDX_MASK = 14'h0FC5;
  // ***********************************************************
  // Fields and reset values
  // ***********************************************************
  localparam int unsigned CTRL_IEN_BIT = 0;
  localparam int unsigned EVT_REQ_FIRST = 0;
  localparam int unsigned EVT_REQ_SECOND = 1;
  localparam int unsigned EVT_ACK = 2;
  localparam logic [7:0] RST_REQ = 8'h00;
  localparam logic [7:0] RST_PSEL = 8'h00;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### pkg/irl_if.sv
// Purpose: Carriers between the top and its latch and bus modules
// Assumes: One clock domain
// Notes:   Modports name the side that owns the state
`timescale 1ns/10ps
`default_nettype none
// ***********************************************************
// Request latch carrier
// ***********************************************************
interface irl_lat_if #(parameter int unsigned W = 8);
  logic [W-1:0] hw_set;
  logic [W-1:0] ack_clr;
  logic [W-1:0] wr_data;
  logic wr_en;
  logic [W-1:0] value;
  modport owner (input hw_set, ack_clr, wr_data, wr_en, output value);
  modport user (output hw_set, ack_clr, wr_data, wr_en, input value);
endinterface
// ***********************************************************
// Register access carrier
// ***********************************************************
interface irl_reg_if;
  logic wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// ### design/irl_latch.sv
// Purpose: One request latch register
// Assumes: Set pulses last one clock
// Notes:   Hardware set beats both write and acknowledge
`timescale 1ns/10ps
`default_nettype none
module irl_latch #(
  parameter int unsigned W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  irl_lat_if.owner lat
);
  typedef struct packed {
    logic [W-1:0] bits;
  } irl_lat_state_t;
  irl_lat_state_t st_r;
  irl_lat_state_t st_nxt;

  // ***********************************************************
  // Next value
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    if (lat.wr_en) begin
      st_nxt.bits = lat.wr_data;
    end
    st_nxt.bits = st_nxt.bits & ~lat.ack_clr;
    st_nxt.bits = st_nxt.bits | lat.hw_set;
  end

  // Register, cleared on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.bits <= W'(irl_pkg::RST_REQ);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lat.value = st_r.bits;

  a_set_wins_all: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (lat.hw_set != '0) |=> ((lat.value & $past(lat.hw_set)) == $past(lat.hw_set)))
    else $error("request pulse lost");
endmodule // irl_latch
`default_nettype wire

// ### design/irl_axil_slave.sv
// Purpose: AXI4-Lite slave front end
// Assumes: One write and one read outstanding at most
// Notes:   Response two edges after both write halves, read one edge after
`timescale 1ns/10ps
`default_nettype none
module irl_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  irl_reg_if.slave rb
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } irl_axi_state_t;
  irl_axi_state_t st_r;
  irl_axi_state_t st_nxt;

  // Held halves go out as one write strobe
  assign rb.wr_en = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rb.wr_addr = st_r.addr;
  assign rb.wr_data = st_r.data;
  assign rb.wr_strb = st_r.strb;
  assign rb.rd_en = arvalid && st_r.arready;
  assign rb.rd_addr = araddr;

  // ***********************************************************
  // Channel handling
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    if (awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.addr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.data = wdata;
      st_nxt.strb = wstrb;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (rb.wr_en) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = rb.wr_err ? irl_pkg::RESP_SLVERR : irl_pkg::RESP_OKAY;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rb.rd_en) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rb.rd_data;
      st_nxt.rresp = rb.rd_err ? irl_pkg::RESP_SLVERR : irl_pkg::RESP_OKAY;
    end
    // Readies are flops so that no AXI channel output is combinational
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  a_write_resp_next: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rb.wr_en |=> bvalid ##0 (bresp == $past(rb.wr_err ? 2'h2 : 2'h0)))
    else $error("write response missing");
endmodule // irl_axil_slave
`default_nettype wire

// ### design/irl_top.sv
// Purpose: Interrupt request latches with global enable and vector out
// Assumes: Request sources are on aclk and pulse for one cycle
// Notes:   Fixed priority, first register bit 7 highest
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Registers show pending requests, no watchdog
// - Request pulse sets first register bit
// - Enabled: pending request goes to core
// - Disabled: pending bits stay readable
// - First register bits timer2 down to converter
// - First register index FC0, clears on reset
// - Pin request sets second register bit
// - Per pin, port A or D only
// - Second register index FC3, clears on reset
// - Acknowledge or written zero clears bit
// - Written one raises, acknowledge clears
// - Enable set and cleared by listed events
module irl_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_two_request,
  input wire logic timer_one_request,
  input wire logic timer_zero_request,
  input wire logic uart_zero_receive_request,
  input wire logic uart_zero_transmit_request,
  input wire logic two_wire_unit_request,
  input wire logic serial_periph_unit_request,
  input wire logic converter_request,
  input wire logic [7:0] port_a_pin_request,
  input wire logic [7:0] port_d_pin_request,
  input wire logic core_enable_insn,
  input wire logic core_disable_insn,
  input wire logic core_trap,
  input wire logic core_iret,
  input wire logic core_ack,
  input wire logic [3:0] core_ack_vector,
  output logic core_irq,
  output logic [3:0] core_irq_vector,
  output logic irq
);
  // ***********************************************************
  // State and carriers
  // ***********************************************************
  typedef struct packed {
    logic ien;
    logic [7:0] psel;
    logic [2:0] mask;
    logic [2:0] status;
    logic core_irq;
    logic [3:0] core_vec;
    logic irq;
  } irl_top_state_t;
  irl_top_state_t st_r;
  irl_top_state_t st_nxt;

  irl_lat_if #(.W(irl_pkg::REG_W)) lat_first ();
  irl_lat_if #(.W(irl_pkg::REG_W)) lat_second ();
  irl_reg_if rb ();

  logic [7:0] first_src;
  logic [7:0] second_src;
  logic [15:0] pend;
  logic [15:0] ack_clr;
  logic [13:0] wr_idx;
  logic [13:0] rd_idx;
  logic wr_go;
  logic [7:0] wr_byte;

  // Highest pending wins; index 0 is first register bit 7
  function automatic logic [3:0] irl_pick(input logic [15:0] p);
    logic [3:0] v;
    v = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (p[i]) begin
        v = 4'(15 - i);
      end
    end
    return v;
  endfunction

  // Decoded index is valid for the registers this block owns
  function automatic logic irl_mapped(input logic [13:0] idx);
    return (idx == irl_pkg::IDX_REQ_FIRST) || (idx == irl_pkg::IDX_CTRL) ||
           (idx == irl_pkg::IDX_PSEL) || (idx == irl_pkg::IDX_REQ_SECOND) ||
           (idx == irl_pkg::IDX_STATUS) || (idx == irl_pkg::IDX_MASK);
  endfunction

  // ***********************************************************
  // Submodules
  // ***********************************************************
  irl_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rb(rb.slave)
  );

  irl_latch #(.W(irl_pkg::REG_W)) u_req_first (
    .aclk(aclk),
    .aresetn(aresetn),
    .lat(lat_first.owner)
  );

  irl_latch #(.W(irl_pkg::REG_W)) u_req_second (
    .aclk(aclk),
    .aresetn(aresetn),
    .lat(lat_second.owner)
  );

  // ***********************************************************
  // Request sources
  // ***********************************************************
  // source to bit order
  assign first_src = {timer_two_request, timer_one_request, timer_zero_request,
                      uart_zero_receive_request, uart_zero_transmit_request,
                      two_wire_unit_request, serial_periph_unit_request,
                      converter_request};
  // one port per pin by select
  assign second_src = (port_a_pin_request & ~st_r.psel) |
                      (port_d_pin_request & st_r.psel);
  // sources pulse, so no edge detect
  assign lat_first.hw_set = first_src;
  assign lat_second.hw_set = second_src;

  assign pend = {lat_first.value, lat_second.value};
  assign ack_clr = core_ack ? (16'h8000 >> core_ack_vector) : 16'h0000;
  assign lat_first.ack_clr = ack_clr[15:8];
  assign lat_second.ack_clr = ack_clr[7:0];

  // ***********************************************************
  // Register writes and reads
  // ***********************************************************
  // Only byte lane 0 carries register data
  assign wr_idx = rb.wr_addr[15:2];
  assign rd_idx = rb.rd_addr[15:2];
  assign wr_go = rb.wr_en && rb.wr_strb[0];
  assign wr_byte = rb.wr_data[7:0];
  assign rb.wr_err = rb.wr_en && !irl_mapped(wr_idx);
  assign rb.rd_err = rb.rd_en && !irl_mapped(rd_idx);

  assign lat_first.wr_en = wr_go && (wr_idx == irl_pkg::IDX_REQ_FIRST);
  assign lat_second.wr_en = wr_go && (wr_idx == irl_pkg::IDX_REQ_SECOND);
  assign lat_first.wr_data = wr_byte;
  assign lat_second.wr_data = wr_byte;

  // pending bits readable whatever the enable
  always_comb begin
    rb.rd_data = 32'h0000_0000;
    case (rd_idx)
      irl_pkg::IDX_REQ_FIRST: rb.rd_data[7:0] = lat_first.value;
      irl_pkg::IDX_CTRL: rb.rd_data[irl_pkg::CTRL_IEN_BIT] = st_r.ien;
      irl_pkg::IDX_PSEL: rb.rd_data[7:0] = st_r.psel;
      irl_pkg::IDX_REQ_SECOND: rb.rd_data[7:0] = lat_second.value;
      irl_pkg::IDX_STATUS: rb.rd_data[2:0] = st_r.status;
      irl_pkg::IDX_MASK: rb.rd_data[2:0] = st_r.mask;
      default: rb.rd_data = 32'h0000_0000;
    endcase
  end

  // ***********************************************************
  // Enable, vector and interrupt state
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    // set by enable or return, write sets or clears
    if (core_enable_insn || core_iret) begin
      st_nxt.ien = 1'b1;
    end
    if (wr_go && (wr_idx == irl_pkg::IDX_CTRL)) begin
      st_nxt.ien = wr_byte[irl_pkg::CTRL_IEN_BIT];
    end
    // disable, trap and acknowledge win, safer
    if (core_disable_insn || core_trap || core_ack) begin
      st_nxt.ien = 1'b0;
    end
    if (wr_go && (wr_idx == irl_pkg::IDX_PSEL)) begin
      st_nxt.psel = wr_byte;
    end
    if (wr_go && (wr_idx == irl_pkg::IDX_MASK)) begin
      st_nxt.mask = wr_byte[2:0];
    end
    // Status is write one to clear; a new event wins over the clear
    if (wr_go && (wr_idx == irl_pkg::IDX_STATUS)) begin
      st_nxt.status = st_nxt.status & ~wr_byte[2:0];
    end
    st_nxt.status[irl_pkg::EVT_REQ_FIRST] =
      st_nxt.status[irl_pkg::EVT_REQ_FIRST] | (|first_src);
    st_nxt.status[irl_pkg::EVT_REQ_SECOND] =
      st_nxt.status[irl_pkg::EVT_REQ_SECOND] | (|second_src);
    st_nxt.status[irl_pkg::EVT_ACK] = st_nxt.status[irl_pkg::EVT_ACK] | core_ack;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    // forward while enabled; the acked bit is dropped at once
    st_nxt.core_irq = st_nxt.ien && (|(pend & ~ack_clr));
    st_nxt.core_vec = irl_pick(pend & ~ack_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.ien <= 1'b0;
      st_r.psel <= irl_pkg::RST_PSEL;
      st_r.mask <= irl_pkg::RST_MASK;
      st_r.status <= irl_pkg::RST_STATUS;
      st_r.core_irq <= 1'b0;
      st_r.core_vec <= 4'h0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign core_irq = st_r.core_irq;
  assign core_irq_vector = st_r.core_vec;
  assign irq = st_r.irq;

  // ***********************************************************
  // Checks
  // ***********************************************************
  a_first_set_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (first_src != 8'h00) |=> ((lat_first.value & $past(first_src)) == $past(first_src)))
    else $error("first register missed a request");

  a_port_select_only: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!lat_second.wr_en && (port_d_pin_request & ~st_r.psel) != 8'h00 &&
     (port_a_pin_request & ~st_r.psel) == 8'h00) |=>
    ((lat_second.value & ~$past(lat_second.value) & ~$past(st_r.psel)) == 8'h00))
    else $error("deselected port raised a request");

  a_second_pin_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((port_a_pin_request & ~st_r.psel) != 8'h00) |=>
    ((lat_second.value & $past(port_a_pin_request & ~st_r.psel)) ==
     $past(port_a_pin_request & ~st_r.psel)))
    else $error("second register missed a pin request");

  a_vector_forward: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r.ien && pend != 16'h0000 && !core_ack && !core_disable_insn &&
     !core_trap && !(wr_go && wr_idx == irl_pkg::IDX_CTRL)) |=> core_irq)
    else $error("enabled request not forwarded");

  a_disabled_quiet: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!st_r.ien && !core_ack && !lat_first.wr_en) [*2] |->
    (!core_irq && ((lat_first.value & $past(lat_first.value)) == $past(lat_first.value))))
    else $error("polled request lost or forwarded");

  a_vector_order: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (core_irq && lat_first.value[7] && $past(lat_first.value[7])) |-> (core_irq_vector == 4'h0))
    else $error("timer two not highest");

  a_ack_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (core_ack && (ack_clr & {first_src, second_src}) == 16'h0000 &&
     !lat_first.wr_en && !lat_second.wr_en) |=>
    ((pend & $past(ack_clr)) == 16'h0000) && !st_r.ien)
    else $error("acknowledge did not clear");

  a_sw_write_val: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (lat_first.wr_en && first_src == 8'h00 && ack_clr[15:8] == 8'h00) |=>
    (lat_first.value == $past(wr_byte)))
    else $error("software write not stored");

  a_reset_clears: assert property (
    @(posedge aclk)
    !aresetn |=> (pend == 16'h0000 && !st_r.ien && !core_irq && !irq))
    else $error("reset did not clear");

  a_enable_sets: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((core_enable_insn || core_iret) && !core_disable_insn && !core_trap &&
     !core_ack && !(wr_go && wr_idx == irl_pkg::IDX_CTRL)) |=> st_r.ien)
    else $error("enable instruction ignored");

  a_second_write_val: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (lat_second.wr_en && second_src == 8'h00 && ack_clr[7:0] == 8'h00) |=>
    (lat_second.value == $past(wr_byte)))
    else $error("second register write not stored");

  a_disable_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (core_disable_insn || core_trap) |=> (!st_r.ien && !core_irq))
    else $error("disable or trap left enable set");

  a_pin_d_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((port_d_pin_request & st_r.psel) != 8'h00) |=>
    ((lat_second.value & $past(port_d_pin_request & st_r.psel)) ==
     $past(port_d_pin_request & st_r.psel)))
    else $error("selected port D pin missed");

  a_ack_drops_irq: assert property (
    @(posedge aclk) disable iff (!aresetn)
    core_ack |=> !core_irq)
    else $error("core request stayed up after acknowledge");

  a_status_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(wr_go && wr_idx == irl_pkg::IDX_STATUS) |=>
    ((st_r.status & $past(st_r.status)) == $past(st_r.status)))
    else $error("status bit dropped without a clear");
endmodule // irl_top
`default_nettype wire

// ### dv/irl_core_model.sv
// Purpose: Core side model that acknowledges vectored requests
// Assumes: One clock, ack is a single cycle pulse
// Notes:   Vector is inverted while idle so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module irl_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic core_irq,
  input wire logic [3:0] core_irq_vector,
  output logic core_ack,
  output logic [3:0] core_ack_vector
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_ack <= 1'b0;
      core_ack_vector <= 4'hF;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      core_ack_vector <= ~core_ack_vector; // Idle vector is junk
    end else if (go && core_irq) begin
      core_ack <= 1'b1;
      core_ack_vector <= core_irq_vector;
    end
  end
endmodule // irl_core_model
`default_nettype wire

// ### dv/tb.sv
// Purpose: Self-checking bench of the request latches
// Assumes: Byte address is four times the register index
// Notes:   Sources are packed into vectors to share one pulse task
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic aclk=0, aresetn=0, go=0;
  logic [15:0] s_axi_awaddr=0, s_axi_araddr=0;
  logic [31:0] s_axi_wdata=0, s_axi_rdata;
  logic [3:0] s_axi_wstrb=0, cv, ackv, ins=0;
  logic s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0, s_axi_arvalid=0, s_axi_rready=0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] src=0, pa=0, pd=0;
  logic ci, ack, irq;
  logic [31:0] d;
  int n_mismatch=0, cmp_count=0;
  irl_top i_irl_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_two_request(src[7]),
    .timer_one_request(src[6]), .timer_zero_request(src[5]),
    .uart_zero_receive_request(src[4]), .uart_zero_transmit_request(src[3]),
    .two_wire_unit_request(src[2]), .serial_periph_unit_request(src[1]),
    .converter_request(src[0]), .port_a_pin_request(pa), .port_d_pin_request(pd),
    .core_enable_insn(ins[3]), .core_disable_insn(ins[2]), .core_trap(ins[1]),
    .core_iret(ins[0]), .core_ack(ack), .core_ack_vector(ackv), .core_irq(ci),
    .core_irq_vector(cv), .irq(irq));
  irl_core_model i_irl_core_model (.aclk, .aresetn, .go, .core_irq(ci),
    .core_irq_vector(cv), .core_ack(ack), .core_ack_vector(ackv));
  initial begin
    forever #4 aclk = ~aclk;
  end
  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  function automatic logic [15:0] ad(input logic [13:0] i);
    return {i, 2'b00};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 60) begin
      n_mismatch++;
      test_done();
    end
  endtask
  // Write one byte; both halves offered together, bready held until bvalid
  task automatic axw(input logic [15:0] a, input logic [7:0] v);
    int n;
    logic aw, w;
    n = 0;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w) && n < 60) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && !aw) begin aw = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready && !w) begin w = 1; s_axi_wvalid <= 0; end
    end
    while (!s_axi_bvalid && n < 60) begin @(posedge aclk); n++; end
    lim(n);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 60);
    lim(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rdc(input string nm, input logic [13:0] i, input logic [7:0] e);
    axr(ad(i));
    chk(nm, {24'h0, e}, d);
    chk("rresp", irl_pkg::RESP_OKAY, r);
  endtask
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge aclk);
    case (k)
      0: src <= v;
      1: pa <= v;
      2: pd <= v;
      default: ins <= v[3:0];
    endcase
    @(posedge aclk);
    {src, pa, pd, ins} <= '0;
    repeat (3) @(posedge aclk);
  endtask
  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_reset();
    rdc("first", irl_pkg::IDX_REQ_FIRST, 8'h00);
    rdc("second", irl_pkg::IDX_REQ_SECOND, 8'h00);
    axr(16'h3F40);
    chk("unmapped rresp", irl_pkg::RESP_SLVERR, r);
    axw(16'h3F40, 8'hFF);
    chk("unmapped bresp", irl_pkg::RESP_SLVERR, r);
    $display("t_reset done");
  endtask
  // Sources in bit order timer two down to converter, polled while disabled
  task automatic t_first();
    logic [7:0] e;
    e = 0;
    for (int i = 7; i >= 0; i--) begin
      pulse(0, 8'h01 << i);
      e[i] = 1;
      rdc("first", irl_pkg::IDX_REQ_FIRST, e);
    end
    chk("core_irq", 0, ci);
    axw(ad(irl_pkg::IDX_REQ_FIRST), 8'h00);
    rdc("first clr", irl_pkg::IDX_REQ_FIRST, 8'h00);
    $display("t_first done");
  endtask
  task automatic t_second();
    pulse(2, 8'hFF);
    rdc("second", irl_pkg::IDX_REQ_SECOND, 8'h00);
    pulse(1, 8'h81);
    rdc("second", irl_pkg::IDX_REQ_SECOND, 8'h81);
    axw(ad(irl_pkg::IDX_PSEL), 8'h0F);
    pulse(1, 8'hFF);
    rdc("second", irl_pkg::IDX_REQ_SECOND, 8'hF1);
    pulse(2, 8'hFF);
    rdc("second", irl_pkg::IDX_REQ_SECOND, 8'hFF);
    axw(ad(irl_pkg::IDX_REQ_SECOND), 8'h00);
    axw(ad(irl_pkg::IDX_PSEL), 8'h00);
    $display("t_second done");
  endtask
  // Software raise, every enable source, then core ack clears bit and enable
  task automatic t_vector();
    int n;
    axw(ad(irl_pkg::IDX_REQ_FIRST), 8'h20);
    chk("irq off", 0, ci);
    pulse(3, 8'h08);
    chk("irq ei", 1, ci);
    chk("vector", 2, cv);
    pulse(3, 8'h04);
    chk("irq di", 0, ci);
    pulse(3, 8'h01);
    chk("irq iret", 1, ci);
    pulse(3, 8'h02);
    chk("irq trap", 0, ci);
    axw(ad(irl_pkg::IDX_CTRL), 8'h01);
    repeat (3) @(posedge aclk);
    chk("irq wr", 1, ci);
    go <= 1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!ack && n < 60);
    lim(n);
    go <= 0;
    repeat (2) @(posedge aclk);
    chk("irq ack", 0, ci);
    rdc("first ack", irl_pkg::IDX_REQ_FIRST, 8'h00);
    rdc("ctrl ack", irl_pkg::IDX_CTRL, 8'h00);
    $display("t_vector done");
  endtask
  task automatic t_irq();
    axw(ad(irl_pkg::IDX_STATUS), 8'h07);
    axw(ad(irl_pkg::IDX_MASK), 8'h01);
    pulse(1, 8'h01);
    chk("irq masked", 0, irq);
    pulse(0, 8'h01);
    chk("irq", 1, irq);
    rdc("status", irl_pkg::IDX_STATUS, 8'h03);
    axw(ad(irl_pkg::IDX_STATUS), 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq clr", 0, irq);
    $display("t_irq done");
  endtask
  // Pulse lands in the very cycle the zero write reaches the latch
  task automatic t_race();
    fork
      axw(ad(irl_pkg::IDX_REQ_FIRST), 8'h00);
      begin
        @(posedge aclk);
        pulse(0, 8'h80);
      end
    join
    rdc("first race", irl_pkg::IDX_REQ_FIRST, 8'h80);
    axw(ad(irl_pkg::IDX_REQ_FIRST), 8'h00);
    $display("t_race done");
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_first();
    t_race();
    t_second();
    t_vector();
    t_irq();
    test_done();
  end
endmodule // tb
`default_nettype wire
